// ### core/irs_device.sv
// two-wire register slave: link logic on scl, register bank side on clk
`timescale 1ns/100ps
module irs_device #(
  parameter logic [3:0] ADDR_FIXED = 4'h6   // arbitrary value for the fixed address nibble
) (
  // device clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  // straps
  input  wire logic        interface_select_a,
  input  wire logic        interface_select_b,
  input  wire logic [2:0]  address_strap_pins,
  // register bank write
  output logic             reg_we,
  output logic [3:0]       reg_waddr,
  output logic [15:0]      reg_wdata,
  // register bank read
  output logic [3:0]       reg_raddr,
  input  wire logic [15:0] reg_rdata,
  // link
  irs_link.device          link
);

  ////////////////////////////////////////////////////////////////////////////
  // link-side state, clocked by scl; the start detector is clocked by sda
  irs_pkg::irs_dev_state_e state, next_state;       // byte role
  logic [3:0]   bitcnt, next_bitcnt;                // next bit slot 0..8
  logic [7:0]   rx_sh, next_rx_sh;                  // receive shifter
  logic [7:0]   tx_sh, next_tx_sh;                  // transmit shifter
  logic         ack_en, next_ack_en;                // acknowledge this byte
  logic         tx_hi, next_tx_hi;                  // high byte on the wire
  logic [3:0]   sel, next_sel;                      // selected register
  logic [7:0]   wr_hi, next_wr_hi;                  // first write byte
  logic [15:0]  wr_word, next_wr_word;              // held write word
  logic [3:0]   wr_addr, next_wr_addr;              // held write register
  logic         wr_tgl, next_wr_tgl;                // write event toggle
  logic         rd_tgl, next_rd_tgl;                // read fetch toggle
  logic         start_seen, next_start_seen;        // last start handled
  logic [1:0]   mode_s1, mode_s2;                   // strap synchroniser
  logic [2:0]   pins_s1, pins_s2;                   // strap synchroniser
  logic         sda_low, next_sda_low;              // drive on falling scl
  logic         start_tgl, next_start_tgl;          // start detector
  logic         enabled;                            // port selected
  logic [7:0]   byte_in;                            // byte incl. current bit

  // clk-side state
  logic         wr_s1, wr_s2, wr_s3;                // write toggle sync
  logic         rd_s1, rd_s2, rd_s3;                // fetch toggle sync
  logic         rd_pend, next_rd_pend;              // bank read in flight
  logic [15:0]  rd_word, next_rd_word;              // word offered to link
  logic         next_reg_we;
  logic [3:0]   next_reg_waddr, next_reg_raddr;
  logic [15:0]  next_reg_wdata;

  // port only answers under the matching strap pattern
  assign enabled = (mode_s2 == irs_pkg::MODE_I2C);
  assign byte_in = {rx_sh[6:0], link.sda};

  // open drain: value tied low, only the enable moves
  assign link.sda_dev_out = 1'b0;
  assign link.sda_dev_oe_n = !sda_low;

  ////////////////////////////////////////////////////////////////////////////
  // start detector: sda falling while scl is high; runs on sda itself since
  // a start has no scl edge of its own
  always_comb begin
    next_start_tgl = link.scl ? !start_tgl : start_tgl;
  end

  always_ff @(negedge link.sda or negedge reset_n) begin
    if (!reset_n) start_tgl <= 1'b0;
    else start_tgl <= next_start_tgl;
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte engine, sampling sda on rising scl
  always_comb begin
    next_state = state;
    next_bitcnt = (bitcnt == irs_pkg::BIT_ACK) ? irs_pkg::BIT_FIRST : bitcnt + 4'h1;
    next_rx_sh = byte_in;
    next_tx_sh = tx_sh;
    next_ack_en = ack_en;
    next_tx_hi = tx_hi;
    next_sel = sel;
    next_wr_hi = wr_hi;
    next_wr_word = wr_word;
    next_wr_addr = wr_addr;
    next_wr_tgl = wr_tgl;
    next_rd_tgl = rd_tgl;
    next_start_seen = start_tgl;
    if (start_tgl != start_seen) begin
      // a fresh start: this edge carries the first address bit
      next_state = irs_pkg::ST_ADDR;
      next_bitcnt = 4'h1;
      next_ack_en = 1'b0;
    end else begin
      unique case (state)
        irs_pkg::ST_IDLE: begin
          // not addressed: ignore the bus until the next start
          next_bitcnt = bitcnt;
          next_rx_sh = rx_sh;
        end
        irs_pkg::ST_RD: begin
          if (bitcnt != irs_pkg::BIT_ACK) begin
            next_tx_sh = {tx_sh[6:0], 1'b0};
          end else if (!link.sda) begin
            // master acknowledged: next byte, word repeats endlessly
            next_tx_sh = tx_hi ? rd_word[7:0] : rd_word[15:8];
            next_tx_hi = !tx_hi;
          end else begin
            // no acknowledge ends the read; the stop follows
            next_state = irs_pkg::ST_IDLE;
          end
        end
        default: begin
          // receiving bytes: address, select, write high, write low
          if (bitcnt == irs_pkg::BIT_LAST) begin
            unique case (state)
              irs_pkg::ST_ADDR: next_ack_en = enabled && (byte_in[7:1] == {ADDR_FIXED, pins_s2});
              irs_pkg::ST_SEL: next_ack_en = (byte_in[7:5] == 3'h0) && !byte_in[0];
              default: next_ack_en = 1'b1;
            endcase
          end else if (bitcnt == irs_pkg::BIT_ACK) begin
            next_rx_sh = rx_sh;
            if (!ack_en) begin
              next_state = irs_pkg::ST_IDLE;
            end else begin
              unique case (state)
                irs_pkg::ST_ADDR: begin
                  if (rx_sh[0]) begin
                    // read address: load high byte of the selected word
                    next_state = irs_pkg::ST_RD;
                    next_tx_sh = rd_word[15:8];
                    next_tx_hi = 1'b1;
                  end else begin
                    next_state = irs_pkg::ST_SEL;
                  end
                end
                irs_pkg::ST_SEL: begin
                  // register number sits in bits 4..1; prefetch it now
                  next_sel = rx_sh[4:1];
                  next_rd_tgl = !rd_tgl;
                  next_state = irs_pkg::ST_WHI;
                end
                irs_pkg::ST_WHI: begin
                  next_wr_hi = rx_sh;
                  next_state = irs_pkg::ST_WLO;
                end
                default: begin
                  // second byte in: publish whole word as one event
                  next_wr_word = {wr_hi, rx_sh};
                  next_wr_addr = sel;
                  next_wr_tgl = !wr_tgl;
                  next_state = irs_pkg::ST_IDLE;
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge link.scl or negedge reset_n) begin
    if (!reset_n) begin
      state <= irs_pkg::ST_IDLE; bitcnt <= irs_pkg::BIT_FIRST;
      rx_sh <= irs_pkg::BYTE_RST; tx_sh <= irs_pkg::BYTE_RST;
      ack_en <= 1'b0; tx_hi <= 1'b1; sel <= irs_pkg::REG_RST;
      wr_hi <= irs_pkg::BYTE_RST; wr_word <= irs_pkg::WORD_RST; wr_addr <= irs_pkg::REG_RST;
      wr_tgl <= 1'b0; rd_tgl <= 1'b0; start_seen <= 1'b0;
      mode_s1 <= 2'h0; mode_s2 <= 2'h0; pins_s1 <= 3'h0; pins_s2 <= 3'h0;
    end else begin
      state <= next_state; bitcnt <= next_bitcnt;
      rx_sh <= next_rx_sh; tx_sh <= next_tx_sh;
      ack_en <= next_ack_en; tx_hi <= next_tx_hi; sel <= next_sel;
      wr_hi <= next_wr_hi; wr_word <= next_wr_word; wr_addr <= next_wr_addr;
      wr_tgl <= next_wr_tgl; rd_tgl <= next_rd_tgl; start_seen <= next_start_seen;
      // straps settle long before the eighth address bit needs them
      mode_s1 <= {interface_select_a, interface_select_b}; mode_s2 <= mode_s1;
      pins_s1 <= address_strap_pins; pins_s2 <= pins_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sda drive changes only on falling scl, keeping it steady while scl is high
  always_comb begin
    if (state == irs_pkg::ST_RD) begin
      next_sda_low = (bitcnt != irs_pkg::BIT_ACK) && !tx_sh[7];
    end else begin
      next_sda_low = (state != irs_pkg::ST_IDLE) && (bitcnt == irs_pkg::BIT_ACK) && ack_en;
    end
  end

  always_ff @(negedge link.scl or negedge reset_n) begin
    if (!reset_n) sda_low <= 1'b0;
    else sda_low <= next_sda_low;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bank side: toggles cross by two flops; the held words are stable well
  // before their toggle is seen, so they are sampled without a second sync
  always_comb begin
    next_reg_we = wr_s2 ^ wr_s3;
    next_reg_waddr = reg_waddr;
    next_reg_wdata = reg_wdata;
    next_reg_raddr = reg_raddr;
    next_rd_pend = 1'b0;
    next_rd_word = rd_word;
    if (wr_s2 ^ wr_s3) begin
      next_reg_waddr = wr_addr;
      next_reg_wdata = wr_word;
    end
    if (rd_s2 ^ rd_s3) begin
      // new selection: address the bank, take its data one cycle later
      next_reg_raddr = sel;
      next_rd_pend = 1'b1;
    end
    if (rd_pend) next_rd_word = reg_rdata;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_s1 <= 1'b0; wr_s2 <= 1'b0; wr_s3 <= 1'b0;
      rd_s1 <= 1'b0; rd_s2 <= 1'b0; rd_s3 <= 1'b0;
      rd_pend <= 1'b0; rd_word <= irs_pkg::WORD_RST;
      reg_we <= 1'b0; reg_waddr <= irs_pkg::REG_RST;
      reg_wdata <= irs_pkg::WORD_RST; reg_raddr <= irs_pkg::REG_RST;
    end else if (ce) begin
      wr_s1 <= wr_tgl; wr_s2 <= wr_s1; wr_s3 <= wr_s2;
      rd_s1 <= rd_tgl; rd_s2 <= rd_s1; rd_s3 <= rd_s2;
      rd_pend <= next_rd_pend; rd_word <= next_rd_word;
      reg_we <= next_reg_we; reg_waddr <= next_reg_waddr;
      reg_wdata <= next_reg_wdata; reg_raddr <= next_reg_raddr;
    end
  end
endmodule

// ### include/irs_pkg.sv
// shared constants and types for the two-wire register slave and its master
package irs_pkg;
  // strap pattern {interface_select_a, interface_select_b} selecting this port
  localparam logic [1:0]  MODE_I2C   = 2'h2;
  // bit slot numbers inside one byte frame
  localparam logic [3:0]  BIT_FIRST  = 4'h0;
  localparam logic [3:0]  BIT_LAST   = 4'h7;
  localparam logic [3:0]  BIT_ACK    = 4'h8;
  // reset values
  localparam logic [15:0] WORD_RST   = 16'h0000;
  localparam logic [7:0]  BYTE_RST   = 8'h00;
  localparam logic [3:0]  REG_RST    = 4'h0;
  // quarter phases of one master bit slot
  localparam logic [1:0]  PH_LOW     = 2'h0;
  localparam logic [1:0]  PH_RISE    = 2'h1;
  localparam logic [1:0]  PH_SAMPLE  = 2'h2;
  localparam logic [1:0]  PH_FALL    = 2'h3;
  // clk cycles per quarter bit slot
  localparam int unsigned QDIV_DEF   = 3;
  // width of the burst word count
  localparam int unsigned WORDS_W    = 8;
  // device link states
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_SEL, ST_WHI, ST_WLO, ST_RD} irs_dev_state_e;
  // master states and transfer steps
  typedef enum logic [1:0] {M_IDLE, M_START, M_BYTE, M_STOP} irs_mst_state_e;
  typedef enum logic [2:0] {S_AW, S_SEL, S_WHI, S_WLO, S_AR, S_RD} irs_step_e;
endpackage

// ### include/irs_link.sv
// two-wire link between the register slave and the bus master
`timescale 1ns/100ps
interface irs_link;
  logic scl;           // serial clock, made by the master only
  logic sda;           // resolved data line, pulled up
  logic sda_dev_out;   // device data drive value
  logic sda_dev_oe_n;  // device drive enable, low while driving
  logic sda_mst_out;   // master data drive value
  logic sda_mst_oe_n;  // master drive enable, low while driving

  // open-drain wired-and with pull-up
  assign sda = ~((~sda_dev_oe_n & ~sda_dev_out) | (~sda_mst_oe_n & ~sda_mst_out));

  modport device (input scl, input sda, output sda_dev_out, output sda_dev_oe_n);
  modport master (output scl, input sda, output sda_mst_out, output sda_mst_oe_n);
endinterface

// ### core/irs_master.sv
// two-wire bus master that writes and burst-reads 16-bit slave registers
`timescale 1ns/100ps
module irs_master #(
  parameter int unsigned QDIV = irs_pkg::QDIV_DEF  // clk cycles per quarter bit
) (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  input  wire logic                         ce,
  // command
  input  wire logic                         cmd_valid,
  output logic                              cmd_ready,
  input  wire logic                         cmd_read,
  input  wire logic [6:0]                   cmd_slave,
  input  wire logic [3:0]                   cmd_reg,
  input  wire logic [15:0]                  cmd_wdata,
  input  wire logic [irs_pkg::WORDS_W-1:0]  cmd_words,
  // answer
  output logic                              rsp_valid,
  output logic [15:0]                       rsp_data,
  output logic                              done,
  output logic                              nack_err,
  // link
  irs_link.master                           link
);
  localparam int unsigned QW = (QDIV < 2) ? 1 : $clog2(QDIV);

  if (QDIV < 1) begin : g_bad_qdiv
    $error("irs_master: QDIV must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state
  irs_pkg::irs_mst_state_e  state, next_state;        // frame state
  irs_pkg::irs_step_e       step, next_step;          // byte within transfer
  logic [1:0]               phase, next_phase;        // quarter of bit slot
  logic [QW-1:0]            qcnt, next_qcnt;          // clock divider
  logic [3:0]               bitn, next_bitn;          // bit slot 0..8
  logic [7:0]               sh, next_sh;              // shift register
  logic                     scl_q, next_scl_q;        // clock drive
  logic                     sda_rel, next_sda_rel;    // 1 releases sda
  logic                     rd, next_rd;              // latched direction
  logic [6:0]               slave, next_slave;        // latched slave address
  logic [3:0]               regn, next_regn;          // latched register
  logic [15:0]              wdata, next_wdata;        // latched write word
  logic [irs_pkg::WORDS_W:0] left, next_left;         // bytes still to read
  logic                     hi, next_hi;              // next rx byte is high
  logic [7:0]               rx_hi, next_rx_hi;        // held high byte
  logic                     ack_ok, next_ack_ok;      // slave acknowledged
  logic                     err, next_err;            // nack seen
  logic                     next_rsp_valid, next_done, next_nack_err;
  logic [15:0]              next_rsp_data;
  logic                     sda_s1, sda_s2;           // sda synchroniser
  logic                     tick;

  assign tick = (qcnt == QW'(QDIV - 1));
  assign cmd_ready = (state == irs_pkg::M_IDLE) && ce;
  assign link.scl = scl_q;
  assign link.sda_mst_out = 1'b0;
  assign link.sda_mst_oe_n = sda_rel;

  ////////////////////////////////////////////////////////////////////////////
  // next-value logic: one bit slot is four quarter phases
  always_comb begin
    next_state = state; next_step = step; next_phase = phase; next_bitn = bitn;
    next_qcnt = tick ? '0 : qcnt + QW'(1);
    next_sh = sh; next_scl_q = scl_q; next_sda_rel = sda_rel;
    next_rd = rd; next_slave = slave; next_regn = regn; next_wdata = wdata;
    next_left = left; next_hi = hi; next_rx_hi = rx_hi; next_ack_ok = ack_ok;
    next_err = err; next_rsp_valid = 1'b0; next_rsp_data = rsp_data;
    next_done = 1'b0; next_nack_err = 1'b0;
    unique case (state)
      irs_pkg::M_IDLE: begin
        next_qcnt = '0;
        if (cmd_valid) begin
          // write frame first, read turns round after the select byte
          next_rd = cmd_read; next_slave = cmd_slave; next_regn = cmd_reg;
          next_wdata = cmd_wdata; next_err = 1'b0; next_phase = irs_pkg::PH_LOW;
          next_left = (cmd_words == '0) ? (irs_pkg::WORDS_W+1)'(2) : {cmd_words, 1'b0};
          next_step = irs_pkg::S_AW; next_state = irs_pkg::M_START;
        end
      end
      irs_pkg::M_START: if (tick) begin
        next_phase = phase + 2'h1;
        unique case (phase)
          irs_pkg::PH_LOW: begin next_scl_q = 1'b0; next_sda_rel = 1'b1; end
          irs_pkg::PH_RISE: next_scl_q = 1'b1;
          irs_pkg::PH_SAMPLE: next_sda_rel = 1'b0;   // sda falls with scl high
          irs_pkg::PH_FALL: begin
            next_scl_q = 1'b0; next_bitn = irs_pkg::BIT_FIRST; next_state = irs_pkg::M_BYTE;
            next_sh = {slave, (step == irs_pkg::S_AR)};  // direction bit
          end
        endcase
      end
      irs_pkg::M_BYTE: if (tick) begin
        next_phase = phase + 2'h1;
        unique case (phase)
          irs_pkg::PH_LOW: begin
            if (bitn != irs_pkg::BIT_ACK) next_sda_rel = (step == irs_pkg::S_RD) | sh[7];
            else next_sda_rel = !((step == irs_pkg::S_RD) && (left != (irs_pkg::WORDS_W+1)'(1)));
          end
          irs_pkg::PH_RISE: next_scl_q = 1'b1;
          irs_pkg::PH_SAMPLE: begin
            if (bitn != irs_pkg::BIT_ACK) next_sh = {sh[6:0], sda_s2};
            else next_ack_ok = !sda_s2;
          end
          irs_pkg::PH_FALL: begin
            next_scl_q = 1'b0;
            next_bitn = bitn + 4'h1;
            if (bitn == irs_pkg::BIT_ACK) begin
              next_bitn = irs_pkg::BIT_FIRST;
              if (step == irs_pkg::S_RD) begin
                next_hi = !hi;
                next_left = left - (irs_pkg::WORDS_W+1)'(1);
                if (hi) next_rx_hi = sh;
                else begin next_rsp_valid = 1'b1; next_rsp_data = {rx_hi, sh}; end
                if (left == (irs_pkg::WORDS_W+1)'(1)) next_state = irs_pkg::M_STOP;
              end else if (!ack_ok) begin
                next_err = 1'b1; next_state = irs_pkg::M_STOP;
              end else begin
                unique case (step)
                  irs_pkg::S_AW: begin next_step = irs_pkg::S_SEL; next_sh = {3'h0, regn, 1'b0}; end
                  irs_pkg::S_SEL: begin
                    if (rd) begin next_step = irs_pkg::S_AR; next_state = irs_pkg::M_START; end
                    else begin next_step = irs_pkg::S_WHI; next_sh = wdata[15:8]; end
                  end
                  irs_pkg::S_WHI: begin next_step = irs_pkg::S_WLO; next_sh = wdata[7:0]; end
                  irs_pkg::S_WLO: next_state = irs_pkg::M_STOP;
                  irs_pkg::S_AR: begin next_step = irs_pkg::S_RD; next_hi = 1'b1; end
                  irs_pkg::S_RD: next_state = irs_pkg::M_STOP;
                endcase
              end
            end
          end
        endcase
      end
      irs_pkg::M_STOP: if (tick) begin
        next_phase = phase + 2'h1;
        unique case (phase)
          irs_pkg::PH_LOW: begin next_scl_q = 1'b0; next_sda_rel = 1'b0; end
          irs_pkg::PH_RISE: next_scl_q = 1'b1;
          irs_pkg::PH_SAMPLE: next_sda_rel = 1'b1;   // sda rises with scl high
          irs_pkg::PH_FALL: begin
            next_done = 1'b1; next_nack_err = err; next_state = irs_pkg::M_IDLE;
          end
        endcase
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers, frozen while ce is low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= irs_pkg::M_IDLE; step <= irs_pkg::S_AW; phase <= irs_pkg::PH_LOW;
      qcnt <= '0; bitn <= irs_pkg::BIT_FIRST; sh <= irs_pkg::BYTE_RST;
      scl_q <= 1'b1; sda_rel <= 1'b1; rd <= 1'b0; slave <= 7'h00;
      regn <= irs_pkg::REG_RST; wdata <= irs_pkg::WORD_RST; left <= '0;
      hi <= 1'b1; rx_hi <= irs_pkg::BYTE_RST; ack_ok <= 1'b0; err <= 1'b0;
      rsp_valid <= 1'b0; rsp_data <= irs_pkg::WORD_RST; done <= 1'b0; nack_err <= 1'b0;
      sda_s1 <= 1'b1; sda_s2 <= 1'b1;
    end else if (ce) begin
      state <= next_state; step <= next_step; phase <= next_phase;
      qcnt <= next_qcnt; bitn <= next_bitn; sh <= next_sh;
      scl_q <= next_scl_q; sda_rel <= next_sda_rel; rd <= next_rd; slave <= next_slave;
      regn <= next_regn; wdata <= next_wdata; left <= next_left;
      hi <= next_hi; rx_hi <= next_rx_hi; ack_ok <= next_ack_ok; err <= next_err;
      rsp_valid <= next_rsp_valid; rsp_data <= next_rsp_data;
      done <= next_done; nack_err <= next_nack_err;
      sda_s1 <= link.sda; sda_s2 <= sda_s1;
    end
  end
endmodule

// ### testbench/irs_asserts.sv
// link protocol checker for the two-wire register slave
`timescale 1ns/100ps
module irs_asserts #(
  parameter int unsigned QDIV = 2,      // clk cycles per quarter bit slot
  parameter logic [6:0]  ADDR = 7'h35   // slave address of the device end
) (
  // device clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // link signals
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic sda_dev_out,
  input  wire logic sda_dev_oe_n,
  input  wire logic sda_mst_out,
  input  wire logic sda_mst_oe_n
);
  localparam int REL_MAX = 48 * QDIV;  // ack plus eight low bits, with margin
  logic [3:0] cnt;       // scl rises seen in this byte
  logic [3:0] byte_idx;  // bytes since last start, saturating
  logic [7:0] sh;        // bits of the current byte
  logic       rw;        // direction bit of the frame
  logic       scl_q;     // scl one sample ago
  logic       sda_q;     // sda one sample ago
  //////////////////////////////////////////////////
  // track bit and byte position; a start clears both
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {cnt, byte_idx, sh, rw} <= '0;
      {scl_q, sda_q} <= 2'b11;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin
        cnt <= 4'h0;
        byte_idx <= 4'h0;
      end else if (scl && !scl_q) begin
        cnt <= cnt + 4'h1;
        sh <= {sh[6:0], sda};
        if (byte_idx == 4'h0 && cnt == 4'h7) rw <= sda;
      end else if (!scl && scl_q && cnt == 4'h9) begin
        cnt <= 4'h0;
        if (byte_idx != 4'hf) byte_idx <= byte_idx + 4'h1;
      end
    end
  end
  //////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_ninth_rise; scl && !scl_q && cnt == 4'h8; endsequence
  property p_hold_high; (scl && scl_q) |-> $stable(sda_dev_oe_n); endproperty
  property p_drive_low; $fell(sda_dev_oe_n) |-> !scl; endproperty
  property p_dev_od; !sda_dev_oe_n |-> !sda_dev_out; endproperty
  property p_mst_od; !sda_mst_oe_n |-> !sda_mst_out; endproperty
  property p_release; $fell(sda_dev_oe_n) |-> ##[1:REL_MAX] sda_dev_oe_n; endproperty
  // after a read address the data bytes are the device's own, so only byte 0 of a read is ack-only
  property p_ack_only; ((byte_idx == 4'h0 || !rw) && !sda_dev_oe_n) |-> cnt >= 4'h8; endproperty
  property p_foreign; s_ninth_rise ##0 (byte_idx == 4'h0 && sh[7:1] != ADDR) |-> sda; endproperty
  // scl high: on the falling sample the device may already drive the next byte's first bit
  property p_read_free; (rw && byte_idx != 4'h0 && cnt == 4'h9 && scl) |-> sda_dev_oe_n; endproperty
  a_hold_high: assert property (p_hold_high) else $error("device data moved while scl high");
  a_drive_low: assert property (p_drive_low) else $error("device drive began with scl high");
  a_dev_od: assert property (p_dev_od) else $error("device drove sda high");
  a_mst_od: assert property (p_mst_od) else $error("master drove sda high");
  a_release: assert property (p_release) else $error("device held sda too long");
  a_ack_only: assert property (p_ack_only) else $error("device drove outside ack slot");
  a_foreign: assert property (p_foreign) else $error("foreign address acknowledged");
  a_read_free: assert property (p_read_free) else $error("device held master ack slot");
endmodule

// ### testbench/testbench.sv
// self-checking bench: master and register slave joined over the link
`timescale 1ns/100ps
module testbench;
  localparam int unsigned QDIV = 2;             // short bit slots keep the run brief
  localparam logic [6:0]  ADDR = {4'h6, 3'h5};  // fixed nibble plus strap pins
  logic clk = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0, cmd_read = 1'b0, cmd_ready, rsp_valid, done, nack_err;
  logic interface_select_a = 1'b1, interface_select_b = 1'b0, reg_we, nk;
  logic [2:0] address_strap_pins = 3'h5;
  logic [3:0] cmd_reg = 4'h0, reg_waddr, reg_raddr;
  logic [6:0] cmd_slave = 7'h00;
  logic [7:0] cmd_words = 8'h01;
  logic [15:0] cmd_wdata = 16'h0000, rsp_data, reg_wdata, reg_rdata, bank[16];
  logic [15:0] rq[$];  // words returned by reads
  int n_errors = 0, checked = 0, n_we = 0, cycles = 0;
  irs_link i_irs_link();
  irs_master #(.QDIV(QDIV)) i_irs_master (.clk, .reset_n, .ce(1'b1), .cmd_valid, .cmd_ready, .cmd_read,
    .cmd_slave, .cmd_reg, .cmd_wdata, .cmd_words, .rsp_valid, .rsp_data, .done, .nack_err, .link(i_irs_link));
  irs_device i_irs_device (.clk, .reset_n, .ce(1'b1), .interface_select_a, .interface_select_b,
    .address_strap_pins, .reg_we, .reg_waddr, .reg_wdata, .reg_raddr, .reg_rdata, .link(i_irs_link));
  irs_asserts #(.QDIV(QDIV), .ADDR(ADDR)) u_chk (.clk, .reset_n, .scl(i_irs_link.scl), .sda(i_irs_link.sda),
    .sda_dev_out(i_irs_link.sda_dev_out), .sda_dev_oe_n(i_irs_link.sda_dev_oe_n),
    .sda_mst_out(i_irs_link.sda_mst_out), .sda_mst_oe_n(i_irs_link.sda_mst_oe_n));
  assign reg_rdata = bank[reg_raddr];
  //////////////////////////////////////////////////
  always #5 clk = ~clk;
  // register bank, read words and verdict capture; a hang ends the run
  always @(posedge clk) begin
    if (reg_we) bank[reg_waddr] <= reg_wdata;
    if (reg_we) n_we <= n_we + 1;
    if (rsp_valid) rq.push_back(rsp_data);
    if (done) nk <= nack_err;
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one command, held until taken, then wait for its end
  task automatic run(input logic rd, input logic [6:0] sl, input logic [3:0] rg, input logic [15:0] wd,
                     input logic [7:0] nw);
    @(negedge clk);
    rq.delete();
    n_we = 0;
    {cmd_read, cmd_slave, cmd_reg, cmd_wdata, cmd_words, cmd_valid} = {rd, sl, rg, wd, nw, 1'b1};
    do @(posedge clk); while (cmd_ready !== 1'b1);
    @(negedge clk) cmd_valid = 1'b0;
    do @(posedge clk); while (done !== 1'b1);
    @(negedge clk);
  endtask
  task automatic t_write_read(input logic [3:0] rg, input logic [15:0] v);
    run(1'b0, ADDR, rg, v, 8'h01);
    check(16'(n_we), 16'h0001);
    check(bank[rg], v);
    check({15'h0, nk}, 16'h0000);
    run(1'b1, ADDR, rg, 16'h0000, 8'h03);
    check(16'(rq.size()), 16'h0003);
    foreach (rq[i]) check(rq[i], v);
    // a word count of zero is served as a single word
    run(1'b1, ADDR, rg, 16'h0000, 8'h00);
    check(16'(rq.size()), 16'h0001);
    check(rq[0], v);
  endtask
  // refused frame: no acknowledge, no register write
  task automatic t_refused(input logic [6:0] sl, input logic a, input logic b);
    {interface_select_a, interface_select_b} = {a, b};
    run(1'b0, sl, 4'h3, 16'h1234, 8'h01);
    check({15'h0, nk}, 16'h0001);
    check(16'(n_we), 16'h0000);
    {interface_select_a, interface_select_b} = 2'b10;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk) reset_n = 1'b1;
    t_write_read(4'h0, 16'ha5c3);
    t_write_read(4'hf, 16'h3c5a);
    t_refused(ADDR ^ 7'h01, 1'b1, 1'b0);
    t_refused(ADDR ^ 7'h40, 1'b1, 1'b0);
    for (int s = 0; s < 4; s++) if (s != 2) t_refused(ADDR, s[1], s[0]);
    t_write_read(4'h9, 16'h5e81);
    tally_and_finish();
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
endmodule
